/* File: rsil_interlock.sv */
// restart interlock, safety outputs and status indications of the receiver
// What this block does
// - release after 0.15 to 4 s unlocks to ON
// - press of 4 s or longer is discarded
// - button held 30 s means fault state
// - red lit while locked and outputs off
// - yellow lit when field clear, awaiting unlock
// - field free and released: green, outputs on
// - trip or supply loss engages the interlock
// - marginal field with alignment display: flashing green
// - button line drives lamp inverse of outputs
`timescale 1ns/1ps
module rsil_interlock #(
    parameter logic [rsil_pkg::CNT_W-1:0] MIN_PRESS_CYCLES =
        rsil_pkg::MIN_PRESS_CYC,
    parameter logic [rsil_pkg::CNT_W-1:0] MAX_PRESS_CYCLES =
        rsil_pkg::MAX_PRESS_CYC,
    parameter logic [rsil_pkg::CNT_W-1:0] STUCK_CYCLES =
        rsil_pkg::STUCK_CYC,
    parameter logic [rsil_pkg::CNT_W-1:0] BLINK_CYCLES =
        rsil_pkg::BLINK_CYC
) (
    input  wire logic                ref_clk,
    input  wire logic                nrst,
    input  wire logic                reset_button_line_in,
    output logic                     reset_button_line_out,
    output logic                     reset_button_line_oe,
    input  wire logic                interlock_select_input,
    input  wire logic                field_clear,
    input  wire logic                field_marginal,
    input  wire logic                align_display_en,
    input  wire logic                supply_fail,
    output logic                     safety_output_first,
    output logic                     safety_output_second,
    output rsil_pkg::rsil_ind_t      status_reg
);
    import rsil_pkg::*;

    // last slot with the lamp let go; declared ahead of its first reader
    localparam logic [SLOT_W-1:0] SAMPLE_END = SLOT_SAMPLE;

    rsil_state_t       state_reg;      // operating state
    rsil_state_t       state_next;
    logic [SLOT_W-1:0] slot_reg;       // shared line time slot
    logic [SLOT_W-1:0] slot_next;
    logic              btn_reg;        // sampled button level
    logic              btn_next;
    logic              btn_prev_reg;   // level one cycle earlier
    logic              res_en_reg;     // interlock function enabled
    logic              res_en_next;
    logic              safety_switching_outputs_reg;       // both safety outputs
    logic              safety_switching_outputs_next;
    logic              lamp_oe_reg;    // driving the lamp this cycle
    logic              lamp_oe_next;
    logic              lamp_reg;       // lamp level
    logic              lamp_next;
    rsil_ind_t         ind_next;       // indications next cycle
    logic [CNT_W-1:0]  blink_cnt_reg;  // flash period divider
    logic [CNT_W-1:0]  blink_cnt_next;
    logic              blink_reg;      // flash phase
    logic              blink_next;
    logic [CNT_W-1:0]  press_cnt;      // cycles the button has been held
    logic              released;       // falling edge of the button
    logic              valid_press;    // release inside the window
    logic              long_release;   // release after the window
    logic              stuck;          // held long enough to call a short
    logic              flash_cond;     // marginal field shown as flashing

    // press duration counter runs while the sampled button is high
    rsil_press_timer u_press_timer (
        .ref_clk   (ref_clk),
        .nrst      (nrst),
        .run       (btn_reg),
        .count_reg (press_cnt)
    );

    // press classification from the held duration
    always_comb begin
        released     = btn_prev_reg && !btn_reg;
        valid_press  = released && (press_cnt >= MIN_PRESS_CYCLES)
                     && (press_cnt < MAX_PRESS_CYCLES);
        long_release = released && (press_cnt >= MAX_PRESS_CYCLES);
        stuck        = btn_reg && (press_cnt >= STUCK_CYCLES - CNT_W'(1));
        flash_cond   = align_display_en && field_marginal && field_clear;
    end

    // line sampling: the lamp drive is let go for two slots so the
    // button level is not masked by our own lamp current
    always_comb begin
        slot_next   = slot_reg + SLOT_W'(1);
        btn_next    = btn_reg;
        res_en_next = res_en_reg;
        if (slot_reg == SLOT_SAMPLE) begin
            btn_next = reset_button_line_in;
            // bridged select follows the button line; judge it only
            // while the button is released, else a bridge looks strapped
            if (!reset_button_line_in) begin
                res_en_next = interlock_select_input;
            end
        end
    end

    // state transitions; fault is left only through power-on reset
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_LOCKED: begin
                if (stuck) begin
                    state_next = ST_FAULT;
                end else if (supply_fail) begin
                    state_next = ST_LOCKED;
                end else if (field_clear && (!res_en_reg || valid_press)) begin
                    state_next = ST_ON;
                end
            end
            ST_ON: begin
                if (stuck) begin
                    state_next = ST_FAULT;
                end else if (supply_fail || !field_clear) begin
                    state_next = ST_LOCKED;
                end
            end
            ST_FAULT: begin
                state_next = ST_FAULT;
            end
            default: begin
                state_next = ST_FAULT;   // illegal code is unsafe
            end
        endcase
    end

    // outputs, lamp and indications follow the next state
    always_comb begin
        safety_switching_outputs_next    = (state_next == ST_ON);
        lamp_next    = !safety_switching_outputs_next;
        lamp_oe_next = lamp_next && (slot_next > SAMPLE_END);
        ind_next.red    = !safety_switching_outputs_next;
        ind_next.yellow = (state_next == ST_LOCKED) && field_clear
                        && res_en_reg;
        if (safety_switching_outputs_next && flash_cond) begin
            ind_next.green         = blink_reg;
            ind_next.segment_flash = 1'b1;
        end else begin
            ind_next.green         = safety_switching_outputs_next;
            ind_next.segment_flash = 1'b0;
        end
    end

    // flash divider: flash phase flips every blink period
    always_comb begin
        if (blink_cnt_reg >= BLINK_CYCLES - CNT_W'(1)) begin
            blink_cnt_next = CNT_ZERO;
            blink_next     = !blink_reg;
        end else begin
            blink_cnt_next = blink_cnt_reg + CNT_W'(1);
            blink_next     = blink_reg;
        end
    end

    // register stage; reset starts locked as after a supply loss
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            state_reg     <= ST_LOCKED;
            slot_reg      <= SLOT_RESET;
            btn_reg       <= 1'b0;
            btn_prev_reg  <= 1'b0;
            res_en_reg    <= RES_EN_RESET;
            safety_switching_outputs_reg      <= 1'b0;
            lamp_reg      <= 1'b0;
            lamp_oe_reg   <= 1'b0;
            status_reg    <= IND_RESET;
            blink_cnt_reg <= CNT_ZERO;
            blink_reg     <= 1'b0;
        end else begin
            state_reg     <= state_next;
            slot_reg      <= slot_next;
            btn_reg       <= btn_next;
            btn_prev_reg  <= btn_reg;
            res_en_reg    <= res_en_next;
            safety_switching_outputs_reg      <= safety_switching_outputs_next;
            lamp_reg      <= lamp_next;
            lamp_oe_reg   <= lamp_oe_next;
            status_reg    <= ind_next;
            blink_cnt_reg <= blink_cnt_next;
            blink_reg     <= blink_next;
        end
    end

    // pins come straight from flip-flops
    assign safety_output_first   = safety_switching_outputs_reg;
    assign safety_output_second  = safety_switching_outputs_reg;
    assign reset_button_line_out = lamp_reg;
    assign reset_button_line_oe  = lamp_oe_reg;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    sequence valid_unlock_s;
        (state_reg == ST_LOCKED) && field_clear && valid_press
        && !supply_fail && !stuck;
    endsequence

    sequence on_trip_s;
        (state_reg == ST_ON) && !stuck && (!field_clear || supply_fail);
    endsequence

    unlock_on_press_a: assert property (
        valid_unlock_s |=> (state_reg == ST_ON) ##0 safety_switching_outputs_reg)
        else $error("valid press did not unlock");
    long_press_ignored_a: assert property (
        (state_reg == ST_LOCKED) && res_en_reg && long_release
        |=> state_reg != ST_ON)
        else $error("over-long press unlocked");
    stuck_button_fault_a: assert property (
        btn_reg && (press_cnt == STUCK_CYCLES - CNT_W'(1))
        |=> (state_reg == ST_FAULT) [*2])
        else $error("stuck button not faulted");
    red_while_locked_a: assert property (
        (state_reg != ST_ON) |-> status_reg.red && !safety_output_first
        && !safety_output_second)
        else $error("red lamp or outputs wrong while locked");
    yellow_ready_a: assert property (
        (state_next == ST_LOCKED) && field_clear && res_en_reg
        |=> status_reg.yellow)
        else $error("yellow not lit while awaiting unlock");
    green_outputs_on_a: assert property (
        (state_next == ST_ON) && !flash_cond
        |=> status_reg.green && safety_switching_outputs_reg && !status_reg.red)
        else $error("green or outputs missing in on state");
    trip_locks_a: assert property (
        on_trip_s |=> (state_reg == ST_LOCKED) ##0 !safety_switching_outputs_reg)
        else $error("trip did not engage interlock");
    marginal_flash_a: assert property (
        (state_next == ST_ON) && flash_cond
        |=> status_reg.segment_flash && (status_reg.green == $past(blink_reg)))
        else $error("marginal field not flashed");
    lamp_inverse_a: assert property (
        reset_button_line_oe |-> reset_button_line_out && !safety_switching_outputs_reg)
        else $error("lamp driven against outputs");
    sample_slot_a: assert property (
        (slot_reg == SLOT_SAMPLE) |=> btn_reg == $past(reset_button_line_in))
        else $error("button not sampled in its slot");
endmodule

/* File: rsil_pkg.sv */
// constants and types shared by the restart interlock design
package rsil_pkg;
    // device clock rate and the press timer width
    localparam int unsigned CLK_HZ      = 40_000_000;
    localparam int unsigned CLK_KHZ     = CLK_HZ / 1000;
    localparam int unsigned CNT_W       = 31;

    // press and indicator times in milliseconds, as specified
    localparam int unsigned MIN_PRESS_MS = 150;
    localparam int unsigned MAX_PRESS_MS = 4000;
    localparam int unsigned STUCK_MS     = 30000;
    localparam int unsigned BLINK_MS     = 250;

    // derived cycle counts; all figures divide exactly at 40 MHz
    localparam logic [CNT_W-1:0] MIN_PRESS_CYC =
        CNT_W'(64'(MIN_PRESS_MS) * 64'(CLK_KHZ));
    localparam logic [CNT_W-1:0] MAX_PRESS_CYC =
        CNT_W'(64'(MAX_PRESS_MS) * 64'(CLK_KHZ));
    localparam logic [CNT_W-1:0] STUCK_CYC =
        CNT_W'(64'(STUCK_MS) * 64'(CLK_KHZ));
    localparam logic [CNT_W-1:0] BLINK_CYC =
        CNT_W'(64'(BLINK_MS) * 64'(CLK_KHZ));

    // shared line slots: released in slots 0 and 1, sampled in slot 1
    localparam int unsigned      SLOT_W      = 4;
    localparam logic [SLOT_W-1:0] SLOT_SAMPLE = 4'h1;
    localparam logic [SLOT_W-1:0] SLOT_RESET  = 4'h0;

    // values after reset
    localparam logic        RES_EN_RESET = 1'b1;
    localparam logic [CNT_W-1:0] CNT_ZERO = 31'h0;

    // operating states of the receiver
    typedef enum logic [1:0] {
        ST_LOCKED,
        ST_ON,
        ST_FAULT
    } rsil_state_t;

    // status indications travel together
    typedef struct packed {
        logic red;
        logic yellow;
        logic green;
        logic segment_flash;
    } rsil_ind_t;

    localparam rsil_ind_t IND_RESET = 4'h8;
endpackage

/* File: rsil_press_timer.sv */
// saturating press duration counter
`timescale 1ns/1ps
module rsil_press_timer (
    input  wire logic                         ref_clk,
    input  wire logic                         nrst,
    input  wire logic                         run,
    output logic      [rsil_pkg::CNT_W-1:0]   count_reg
);
    import rsil_pkg::*;

    logic [CNT_W-1:0] count_next;   // next count

    // counts while run is high, clears when it drops, never wraps
    always_comb begin
        if (!run) begin
            count_next = CNT_ZERO;
        end else if (&count_reg) begin
            count_next = count_reg;   // saturate: a wrap would fake a short press
        end else begin
            count_next = count_reg + CNT_W'(1);
        end
    end

    // register stage
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            count_reg <= CNT_ZERO;
        end else begin
            count_reg <= count_next;
        end
    end
endmodule

/* File: rsil_button_model.sv */
// reset push button and select wiring seen from outside the receiver
`timescale 1ns/1ps
module rsil_button_model (
    input  wire logic pressed,
    input  wire logic bridged,
    input  wire logic lamp_level,
    input  wire logic lamp_oe,
    output logic      line_level,
    output logic      select_level
);
    // contact to supply when pressed, pull-down when nobody drives
    assign line_level = pressed | (lamp_oe & lamp_level);
    // select strapped high, or bridged onto the button line
    assign select_level = bridged ? line_level : 1'b1;
endmodule

/* File: tb_top.sv */
// self-checking bench for the restart interlock block
`timescale 1ns/1ps
module tb_top;
    import rsil_pkg::*;
    logic      ref_clk     = 1'b0;
    logic      nrst        = 1'b0;
    logic      pressed     = 1'b0; // button held by the operator
    logic      bridged     = 1'b0; // select wired onto button line
    logic      field_clear = 1'b1;
    logic      marginal    = 1'b0;
    logic      align_en    = 1'b0;
    logic      supply_fail = 1'b0;
    logic      line_in;
    logic      line_out;
    logic      line_oe;
    logic      select_in;
    logic      out_a;
    logic      out_b;
    rsil_ind_t status;
    int        num_errors  = 0;
    int        checks      = 0;

    // 40 MHz device clock
    always #12.5 ref_clk = ~ref_clk;

    // short counts keep the run brief; the waits below are fixed figures picked to suit these
    rsil_interlock #(
        .MIN_PRESS_CYCLES(31'h14),
        .MAX_PRESS_CYCLES(31'h64),
        .STUCK_CYCLES    (31'h190),
        .BLINK_CYCLES    (31'h8)
    ) u_rsil_interlock (
        .ref_clk               (ref_clk),
        .nrst                  (nrst),
        .reset_button_line_in  (line_in),
        .reset_button_line_out (line_out),
        .reset_button_line_oe  (line_oe),
        .interlock_select_input(select_in),
        .field_clear           (field_clear),
        .field_marginal        (marginal),
        .align_display_en      (align_en),
        .supply_fail           (supply_fail),
        .safety_output_first   (out_a),
        .safety_output_second  (out_b),
        .status_reg            (status)
    );

    rsil_button_model u_rsil_button_model (
        .pressed     (pressed),
        .bridged     (bridged),
        .lamp_level  (line_out),
        .lamp_oe     (line_oe),
        .line_level  (line_in),
        .select_level(select_in)
    );

    // one comparison, counted and reported on mismatch
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask

    task automatic press_for(input int n);
        pressed = 1'b1;
        cyc(n);
        pressed = 1'b0;
    endtask

    // bounded wait for the outputs to switch on
    task automatic wait_on(input int n);
        int i;
        for (i = 0; i < n && out_a !== 1'b1; i++) cyc(1);
    endtask

    task automatic complete_run;
        if (num_errors == 0 && checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    // locked after power-up: red and yellow, lamp lit outside slots
    task automatic s_power_up;
        int n;
        n = 0;
        chk({4'h0, status}, 8'h0c);
        chk({6'h0, out_a, out_b}, 8'h00);
        chk({7'h0, line_out}, 8'h01);
        repeat (16) begin
            cyc(1);
            n += (line_oe === 1'b1) ? 1 : 0;
        end
        chk(8'(n), 8'h0e);
    endtask

    // press inside the window unlocks; lamp goes dark
    task automatic s_unlock;
        press_for(48);
        wait_on(40);
        chk({6'h0, out_a, out_b}, 8'h03);
        chk({4'h0, status}, 8'h02);
        chk({6'h0, line_out, line_oe}, 8'h00);
    endtask

    // field trip and supply loss both relock
    task automatic s_trips;
        field_clear = 1'b0;
        cyc(1);
        chk({6'h0, out_a, out_b}, 8'h00);
        chk({4'h0, status}, 8'h08);
        field_clear = 1'b1;
        cyc(40);
        chk({6'h0, out_a, out_b}, 8'h00);
        chk({4'h0, status}, 8'h0c);
        s_unlock();
        supply_fail = 1'b1;
        cyc(1);
        supply_fail = 1'b0;
        cyc(40);
        chk({6'h0, out_a, out_b}, 8'h00);
    endtask

    // too short and too long presses are discarded
    task automatic s_press_limits;
        press_for(8);
        cyc(40);
        chk({6'h0, out_a, out_b}, 8'h00);
        press_for(160);
        cyc(40);
        chk({6'h0, out_a, out_b}, 8'h00);
        s_unlock();
    endtask

    // marginal field with alignment display blinks green
    task automatic s_blink;
        logic g;
        marginal = 1'b1;
        align_en = 1'b1;
        cyc(2);
        g = status.green;
        chk({7'h0, status.segment_flash}, 8'h01);
        cyc(8);
        chk({7'h0, status.green}, {7'h0, ~g});
        field_clear = 1'b0;
        cyc(1);
        chk({7'h0, status.red}, 8'h01);
        marginal = 1'b0;
        align_en = 1'b0;
        field_clear = 1'b1;
        cyc(2);
    endtask

    // bridged select lets the outputs return without a press
    task automatic s_bridge;
        bridged = 1'b1;
        press_for(48);
        wait_on(40);
        cyc(40);
        field_clear = 1'b0;
        cyc(2);
        field_clear = 1'b1;
        wait_on(40);
        chk({6'h0, out_a, out_b}, 8'h03);
        bridged = 1'b0;
        cyc(40);
        field_clear = 1'b0;
        cyc(2);
        field_clear = 1'b1;
        cyc(40);
        chk({6'h0, out_a, out_b}, 8'h00);
    endtask

    // stuck button faults; only reset clears it
    task automatic s_stuck;
        press_for(500);
        cyc(40);
        press_for(48);
        cyc(40);
        chk({6'h0, out_a, out_b}, 8'h00);
        chk({4'h0, status}, 8'h08);
        nrst = 1'b0;
        cyc(2);
        nrst = 1'b1;
        cyc(2);
        chk({4'h0, status}, 8'h0c);
        s_unlock();
    endtask

    initial begin
        cyc(3);
        nrst = 1'b1;
        cyc(2);
        s_power_up();
        s_unlock();
        s_trips();
        s_press_limits();
        s_blink();
        s_bridge();
        s_stuck();
        complete_run();
    end

    // run needs some 1500 cycles; cut a hang after 20000
    initial begin
        #500000;
        num_errors++;
        complete_run();
    end
endmodule
